// >>> rtl/mkd_pkg.sv
package mkd_pkg;
  // Parameter kind and instance codes, all seven bits wide
  localparam logic [6:0] KIND_KEY     = 7'h35;   // 0110101, channel key
  localparam logic [6:0] KIND_SEQ     = 7'h36;   // 0110110, sequence number
  localparam logic [6:0] INST_BASE    = 7'h38;   // 0111000, instance 0
  localparam int         KEY_W        = 128;     // Key width in bits
  localparam int         SEQ_W        = 48;      // Sequence number width
  localparam int         INST_W       = 3;       // Instance number width
  // Retrieval supervision time, microseconds, and clock rate
  localparam int         SUP_TIME_US  = 1000;    // Default supervision time
  localparam int         CLK_MHZ      = 250;     // Core clock rate
  localparam int         SUP_CYCLES   = SUP_TIME_US * CLK_MHZ;
  localparam int         SUP_CNT_W    = 32;      // Supervision counter width
  localparam logic [1:0] LFSR_RST_HI  = 2'h1;    // Nonzero seed marker

  // Message types on the link
  typedef enum logic [2:0] {
    MKD_MSG_NONE,
    MKD_MSG_SUGGEST,
    MKD_MSG_ACCEPT,
    MKD_MSG_REQUEST,
    MKD_MSG_REJECT,
    MKD_MSG_NOTIFY
  } mkd_msg_t;
endpackage

// >>> rtl/mkd_link_if.sv
`timescale 1ns/10ps
// Message link between the fixed side and the portable side
interface mkd_link_if;
  // Fixed to portable
  logic                           f2p_valid;     // One-cycle message strobe
  mkd_pkg::mkd_msg_t              f2p_type;      // Message type
  logic                           f2p_has_key;   // Kind carries key code
  logic                           f2p_has_seq;   // Kind carries sequence code
  logic                           f2p_has_inst;  // Instance indicator present
  logic [mkd_pkg::INST_W-1:0]     f2p_inst;      // Instance number
  logic [mkd_pkg::KEY_W-1:0]      f2p_key;       // Key element payload
  logic [mkd_pkg::SEQ_W-1:0]      f2p_seq;       // Sequence seed element
  logic                           f2p_restart;   // Timer-restart element
  // Portable to fixed
  logic                           p2f_valid;
  mkd_pkg::mkd_msg_t              p2f_type;
  logic                           p2f_has_key;
  logic                           p2f_has_seq;
  logic                           p2f_has_inst;
  logic [mkd_pkg::INST_W-1:0]     p2f_inst;
  // Both ends see the same encryption status of the link
  logic                           link_encrypted;

  modport fixed_side (
    output f2p_valid, f2p_type, f2p_has_key, f2p_has_seq, f2p_has_inst, f2p_inst,
           f2p_key, f2p_seq, f2p_restart,
    input  p2f_valid, p2f_type, p2f_has_key, p2f_has_seq, p2f_has_inst, p2f_inst,
           link_encrypted
  );
  modport portable_side (
    input  f2p_valid, f2p_type, f2p_has_key, f2p_has_seq, f2p_has_inst, f2p_inst,
           f2p_key, f2p_seq, f2p_restart, link_encrypted,
    output p2f_valid, p2f_type, p2f_has_key, p2f_has_seq, p2f_has_inst, p2f_inst
  );
endinterface // mkd_link_if

// >>> rtl/mkd_fixed_side.sv
`timescale 1ns/10ps
// How it works
// - Key from random generator, separate from others
// - Send key messages only over encrypted link
// - Suggest carries 128-bit key element
// - Suggest carries 48-bit sequence seed element
// - Suggest carries key, sequence, or both
// - Suggest then accept with kind and instance
// - Accept never carries key or sequence
// - Every message except notify carries parameter kind
// - Kind codes 0110101 key, 0110110 sequence
// - Missing instance means zero; echo indicator
// - Instances 0..7 coded 0111000..0111111
// - One instance indicator, no other codes
// - Request answered by closing suggest, no accept
// - Request kind names exactly what is wanted
// - Portable retries once, then aborts
// - Notify with restart restarts portable timer
// - Either side may reject, ending exchange
// - Reject copies starting kind element exactly
// - Reject never carries key or sequence
module mkd_fixed_side (
  input  wire logic                         core_clk,
  input  wire logic                         reset_n,
  mkd_link_if.fixed_side                    link,
  input  wire logic                         assign_go,      // Start an assignment
  input  wire logic                         assign_key,     // Assign the key
  input  wire logic                         assign_seq,     // Assign the sequence
  input  wire logic                         assign_has_inst,
  input  wire logic [mkd_pkg::INST_W-1:0]   assign_inst,
  input  wire logic [mkd_pkg::SEQ_W-1:0]    assign_seq_val, // Sequence to hand out
  input  wire logic                         retr_refuse,    // Refuse retrievals
  input  wire logic                         restart_go,     // Send timer restart
  output logic                              busy,           // Assignment pending
  output logic                              done_ok,        // Accept seen, pulse
  output logic                              done_rej,       // Reject seen, pulse
  output logic [mkd_pkg::KEY_W-1:0]         cur_key         // Last issued key
);
  typedef enum logic [1:0] {FS_IDLE, FS_WAIT} mkd_fs_state_t;

  mkd_fs_state_t                 state_r;     // Assignment state
  logic [mkd_pkg::KEY_W-1:0]     lfsr_r;      // Free-running random source
  logic                          pend_key_r;  // Kind of open assignment
  logic                          pend_seq_r;
  logic                          pend_hi_r;   // Instance indicator used
  logic [mkd_pkg::INST_W-1:0]    pend_inst_r;
  logic                          req_ok;      // Request well formed
  logic                          msg_match;   // Answer matches open assignment

  // Request legal only if it names at least one parameter
  assign req_ok    = link.p2f_has_key | link.p2f_has_seq;
  assign msg_match = (link.p2f_has_key == pend_key_r) && (link.p2f_has_seq == pend_seq_r) &&
                     (link.p2f_has_inst == pend_hi_r) &&
                     (!pend_hi_r || link.p2f_inst == pend_inst_r);

  // Random generator; its own state, never shared with unicast keys
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lfsr_r <= {{(mkd_pkg::KEY_W-2){1'b0}}, mkd_pkg::LFSR_RST_HI};
    end else begin
      lfsr_r <= {lfsr_r[mkd_pkg::KEY_W-2:0],
                 lfsr_r[127] ^ lfsr_r[125] ^ lfsr_r[100] ^ lfsr_r[98]};
    end
  end

  // Assignment state and outcome
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r     <= FS_IDLE;
      pend_key_r  <= 1'b0;
      pend_seq_r  <= 1'b0;
      pend_hi_r   <= 1'b0;
      pend_inst_r <= '0;
      busy        <= 1'b0;
      done_ok     <= 1'b0;
      done_rej    <= 1'b0;
      cur_key     <= '0;
    end else begin
      done_ok  <= 1'b0;
      done_rej <= 1'b0;
      case (state_r)
        FS_IDLE: begin
          // Only start when encrypted and something to hand out
          if (assign_go && link.link_encrypted && (assign_key | assign_seq)) begin
            state_r     <= FS_WAIT;
            busy        <= 1'b1;
            pend_key_r  <= assign_key;
            pend_seq_r  <= assign_seq;
            pend_hi_r   <= assign_has_inst;
            pend_inst_r <= assign_has_inst ? assign_inst : '0;
            if (assign_key) begin
              cur_key <= lfsr_r;
            end
          end
        end
        FS_WAIT: begin
          // Accept or reject closes the assignment
          if (link.p2f_valid && msg_match && link.p2f_type == mkd_pkg::MKD_MSG_ACCEPT) begin
            state_r <= FS_IDLE;
            busy    <= 1'b0;
            done_ok <= 1'b1;
          end else if (link.p2f_valid && msg_match && link.p2f_type == mkd_pkg::MKD_MSG_REJECT) begin
            state_r  <= FS_IDLE;
            busy     <= 1'b0;
            done_rej <= 1'b1;
          end
        end
        default: begin
          state_r <= FS_IDLE;
          busy    <= 1'b0;
        end
      endcase
    end
  end

  // Outgoing messages: suggest, reply to request, notify
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      link.f2p_valid    <= 1'b0;
      link.f2p_type     <= mkd_pkg::MKD_MSG_NONE;
      link.f2p_has_key  <= 1'b0;
      link.f2p_has_seq  <= 1'b0;
      link.f2p_has_inst <= 1'b0;
      link.f2p_inst     <= '0;
      link.f2p_key      <= '0;
      link.f2p_seq      <= '0;
      link.f2p_restart  <= 1'b0;
    end else begin
      link.f2p_valid   <= 1'b0;
      link.f2p_restart <= 1'b0;
      if (state_r == FS_IDLE && assign_go && link.link_encrypted && (assign_key | assign_seq)) begin
        // Assignment suggest carries kind, instance and parameters
        link.f2p_valid    <= 1'b1;
        link.f2p_type     <= mkd_pkg::MKD_MSG_SUGGEST;
        link.f2p_has_key  <= assign_key;
        link.f2p_has_seq  <= assign_seq;
        link.f2p_has_inst <= assign_has_inst;
        link.f2p_inst     <= assign_has_inst ? assign_inst : '0;
        link.f2p_key      <= assign_key ? lfsr_r : '0;
        link.f2p_seq      <= assign_seq ? assign_seq_val : '0;
      end else if (link.p2f_valid && link.p2f_type == mkd_pkg::MKD_MSG_REQUEST && link.link_encrypted) begin
        // Retrieval: closing suggest or reject, kind copied from request
        link.f2p_valid    <= 1'b1;
        link.f2p_type     <= (retr_refuse || !req_ok) ? mkd_pkg::MKD_MSG_REJECT
                                                      : mkd_pkg::MKD_MSG_SUGGEST;
        link.f2p_has_key  <= link.p2f_has_key;
        link.f2p_has_seq  <= link.p2f_has_seq;
        link.f2p_has_inst <= link.p2f_has_inst;
        link.f2p_inst     <= link.p2f_inst;
        link.f2p_key      <= (!retr_refuse && req_ok && link.p2f_has_key) ? cur_key : '0;
        link.f2p_seq      <= (!retr_refuse && req_ok && link.p2f_has_seq) ? assign_seq_val : '0;
      end else if (restart_go && link.link_encrypted) begin
        // Notify with timer restart, no parameters
        link.f2p_valid    <= 1'b1;
        link.f2p_type     <= mkd_pkg::MKD_MSG_NOTIFY;
        link.f2p_restart  <= 1'b1;
        link.f2p_has_key  <= 1'b0;
        link.f2p_has_seq  <= 1'b0;
        link.f2p_has_inst <= 1'b0;
        link.f2p_key      <= '0;
        link.f2p_seq      <= '0;
      end
    end
  end
endmodule // mkd_fixed_side

// >>> rtl/mkd_portable_side.sv
`timescale 1ns/10ps
// Portable end: answers assignments, runs supervised retrieval
module mkd_portable_side #(
  parameter int SUP_CYCLES = mkd_pkg::SUP_CYCLES   // Supervision time in cycles
) (
  input  wire logic                         core_clk,
  input  wire logic                         reset_n,
  mkd_link_if.portable_side                 link,
  input  wire logic                         refuse,        // Reject suggests while no retrieval open
  input  wire logic                         retr_go,       // Start retrieval
  input  wire logic                         retr_key,      // Want key
  input  wire logic                         retr_seq,      // Want sequence
  input  wire logic                         retr_has_inst,
  input  wire logic [mkd_pkg::INST_W-1:0]   retr_inst,
  output logic                              retr_busy,     // Retrieval open
  output logic                              retr_done,     // Parameters got, pulse
  output logic                              retr_fail,     // Rejected/aborted, pulse
  output logic                              key_valid,     // Key held
  output logic [mkd_pkg::KEY_W-1:0]         key_out,
  output logic [mkd_pkg::INST_W-1:0]        key_inst,
  output logic                              seq_valid,
  output logic [mkd_pkg::SEQ_W-1:0]         seq_out
);
  typedef enum logic [1:0] {PS_IDLE, PS_WAIT} mkd_ps_state_t;

  mkd_ps_state_t                 state_r;     // Retrieval state
  logic [mkd_pkg::SUP_CNT_W-1:0] tmr_r;       // Supervision timer
  logic                          expired_r;   // First expiry seen
  logic                          rq_key_r;    // Kind of open request
  logic                          rq_seq_r;
  logic                          rq_hi_r;
  logic [mkd_pkg::INST_W-1:0]    rq_inst_r;
  logic                          tmo;         // Timer expires now
  logic                          rx_sug;      // Suggest arrives
  logic                          ans_match;   // Answer matches open request

  localparam int SUP_CNT = mkd_pkg::SUP_CNT_W;  // Width of timer reload casts

  assign tmo       = (tmr_r == '0);
  assign rx_sug    = link.f2p_valid && link.f2p_type == mkd_pkg::MKD_MSG_SUGGEST;
  assign ans_match = (link.f2p_has_key == rq_key_r) && (link.f2p_has_seq == rq_seq_r) &&
                     (link.f2p_has_inst == rq_hi_r) && (!rq_hi_r || link.f2p_inst == rq_inst_r);

  // Retrieval control, timer, retry and abort
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_r   <= PS_IDLE;
      tmr_r     <= '0;
      expired_r <= 1'b0;
      rq_key_r  <= 1'b0;
      rq_seq_r  <= 1'b0;
      rq_hi_r   <= 1'b0;
      rq_inst_r <= '0;
      retr_busy <= 1'b0;
      retr_done <= 1'b0;
      retr_fail <= 1'b0;
    end else begin
      retr_done <= 1'b0;
      retr_fail <= 1'b0;
      case (state_r)
        PS_IDLE: begin
          if (retr_go && link.link_encrypted && (retr_key | retr_seq)) begin
            state_r   <= PS_WAIT;
            retr_busy <= 1'b1;
            expired_r <= 1'b0;
            tmr_r     <= SUP_CNT'(SUP_CYCLES - 1);
            rq_key_r  <= retr_key;
            rq_seq_r  <= retr_seq;
            rq_hi_r   <= retr_has_inst;
            rq_inst_r <= retr_has_inst ? retr_inst : '0;
          end
        end
        PS_WAIT: begin
          if (link.f2p_valid && ans_match && (rx_sug || link.f2p_type == mkd_pkg::MKD_MSG_REJECT)) begin
            // Closing suggest or reject ends the exchange
            state_r   <= PS_IDLE;
            retr_busy <= 1'b0;
            retr_done <= rx_sug;
            retr_fail <= !rx_sug;
          end else if (link.f2p_valid && link.f2p_type == mkd_pkg::MKD_MSG_NOTIFY && link.f2p_restart) begin
            tmr_r <= SUP_CNT'(SUP_CYCLES - 1);
          end else if (tmo && expired_r) begin
            state_r   <= PS_IDLE;
            retr_busy <= 1'b0;
            retr_fail <= 1'b1;
          end else if (tmo) begin
            expired_r <= 1'b1;
            tmr_r     <= SUP_CNT'(SUP_CYCLES - 1);
          end else begin
            tmr_r <= tmr_r - 1'b1;
          end
        end
        default: begin
          state_r   <= PS_IDLE;
          retr_busy <= 1'b0;
        end
      endcase
    end
  end

  // Store received parameters, absent instance taken as zero
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      key_valid <= 1'b0;
      key_out   <= '0;
      key_inst  <= '0;
      seq_valid <= 1'b0;
      seq_out   <= '0;
    end else if (rx_sug && !(state_r == PS_IDLE && refuse)) begin
      if (link.f2p_has_key) begin
        key_valid <= 1'b1;
        key_out   <= link.f2p_key;
        key_inst  <= link.f2p_has_inst ? link.f2p_inst : '0;
      end
      if (link.f2p_has_seq) begin
        seq_valid <= 1'b1;
        seq_out   <= link.f2p_seq;
      end
    end
  end

  // Outgoing messages: accept, reject, request and its single resend
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      link.p2f_valid    <= 1'b0;
      link.p2f_type     <= mkd_pkg::MKD_MSG_NONE;
      link.p2f_has_key  <= 1'b0;
      link.p2f_has_seq  <= 1'b0;
      link.p2f_has_inst <= 1'b0;
      link.p2f_inst     <= '0;
    end else begin
      link.p2f_valid <= 1'b0;
      if (state_r == PS_IDLE && rx_sug && link.link_encrypted) begin
        // Answer an assignment; kind copied, never parameters
        link.p2f_valid    <= 1'b1;
        link.p2f_type     <= refuse ? mkd_pkg::MKD_MSG_REJECT : mkd_pkg::MKD_MSG_ACCEPT;
        link.p2f_has_key  <= link.f2p_has_key;
        link.p2f_has_seq  <= link.f2p_has_seq;
        link.p2f_has_inst <= link.f2p_has_inst;
        link.p2f_inst     <= link.f2p_inst;
      end else if (state_r == PS_IDLE && retr_go && link.link_encrypted && (retr_key | retr_seq)) begin
        link.p2f_valid    <= 1'b1;
        link.p2f_type     <= mkd_pkg::MKD_MSG_REQUEST;
        link.p2f_has_key  <= retr_key;
        link.p2f_has_seq  <= retr_seq;
        link.p2f_has_inst <= retr_has_inst;
        link.p2f_inst     <= retr_has_inst ? retr_inst : '0;
      end else if (state_r == PS_WAIT && tmo && !expired_r && !link.f2p_valid && link.link_encrypted) begin
        // Resend same request on first expiry
        link.p2f_valid    <= 1'b1;
        link.p2f_type     <= mkd_pkg::MKD_MSG_REQUEST;
        link.p2f_has_key  <= rq_key_r;
        link.p2f_has_seq  <= rq_seq_r;
        link.p2f_has_inst <= rq_hi_r;
        link.p2f_inst     <= rq_inst_r;
      end
    end
  end
endmodule // mkd_portable_side

// >>> tb/mkd_link_props.sv
`timescale 1ns/10ps
// Watches the link between the two ends
module mkd_link_props #(
  parameter int SUP_CYCLES = 20          // Portable supervision time
) (
  input wire logic                       core_clk,
  input wire logic                       reset_n,
  input wire logic                       f2p_valid,
  input mkd_pkg::mkd_msg_t               f2p_type,
  input wire logic                       f2p_has_key,
  input wire logic                       f2p_has_seq,
  input wire logic                       f2p_has_inst,
  input wire logic [mkd_pkg::INST_W-1:0] f2p_inst,
  input wire logic [mkd_pkg::KEY_W-1:0]  f2p_key,
  input wire logic [mkd_pkg::SEQ_W-1:0]  f2p_seq,
  input wire logic                       f2p_restart,
  input wire logic                       p2f_valid,
  input mkd_pkg::mkd_msg_t               p2f_type,
  input wire logic                       p2f_has_key,
  input wire logic                       p2f_has_seq,
  input wire logic                       p2f_has_inst,
  input wire logic [mkd_pkg::INST_W-1:0] p2f_inst,
  input wire logic                       link_encrypted
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [5:0] fk, pk;                    // Kind and instance fields
  logic       f_sug, f_rej, f_ntf;       // Fixed end messages
  logic       p_acc, p_rej, p_req;       // Portable end messages
  logic       pend_r;                    // Request awaiting an answer
  int         gap_r;                     // Cycles since last request or fixed end message
  assign fk = {f2p_has_key, f2p_has_seq, f2p_has_inst, f2p_inst};
  assign pk = {p2f_has_key, p2f_has_seq, p2f_has_inst, p2f_inst};
  assign f_sug = f2p_valid && f2p_type == mkd_pkg::MKD_MSG_SUGGEST;
  assign f_rej = f2p_valid && f2p_type == mkd_pkg::MKD_MSG_REJECT;
  assign f_ntf = f2p_valid && f2p_type == mkd_pkg::MKD_MSG_NOTIFY;
  assign p_acc = p2f_valid && p2f_type == mkd_pkg::MKD_MSG_ACCEPT;
  assign p_rej = p2f_valid && p2f_type == mkd_pkg::MKD_MSG_REJECT;
  assign p_req = p2f_valid && p2f_type == mkd_pkg::MKD_MSG_REQUEST;
  // Notify keeps the request open; any other answer closes it
  always_ff @(posedge core_clk) begin
    if (!reset_n) pend_r <= 1'h0;
    else if (p_req) pend_r <= 1'h1;
    else if (f2p_valid && !f_ntf) pend_r <= 1'h0;
  end
  // Saturating gap so a long idle spell cannot wrap
  always_ff @(posedge core_clk) begin
    if (!reset_n || p_req || f2p_valid) gap_r <= 0;
    else if (gap_r < 1000000) gap_r <= gap_r + 1;
  end
  a_send_encrypted: assert property ((f2p_valid || p2f_valid) |-> $past(link_encrypted))
    else $error("message sent on a clear link");
  a_suggest_kind: assert property (f_sug |-> f2p_has_key || f2p_has_seq)
    else $error("suggest without parameter kind");
  a_absent_zero: assert property (f_sug |-> (f2p_has_key || f2p_key == '0) && (f2p_has_seq || f2p_seq == '0))
    else $error("absent parameter not zero");
  a_accept_copies: assert property (p_acc |-> $past(f_sug) && pk == $past(fk))
    else $error("accept does not echo the suggest");
  a_reject_copies: assert property (p_rej |-> $past(f_sug) && pk == $past(fk))
    else $error("reject does not echo the suggest");
  a_request_answer: assert property (p_req && link_encrypted |=> (f_sug || f_rej) && fk == $past(pk))
    else $error("request not answered with echoed kind");
  a_reject_clean: assert property (f_rej |-> f2p_key == '0 && f2p_seq == '0)
    else $error("reject carries parameters");
  a_request_kind: assert property (p_req |-> p2f_has_key || p2f_has_seq)
    else $error("request names nothing");
  a_retry_gap: assert property (p_req && pend_r |-> gap_r >= SUP_CYCLES - 2)
    else $error("request repeated too early");
  a_notify_restart: assert property (f_ntf |-> f2p_restart)
    else $error("notify without timer restart");
  c_accept: cover property (p_acc);
  c_pt_reject: cover property (p_rej);
  c_retrieval: cover property (p_req ##1 f_sug);
endmodule // mkd_link_props

// >>> tb/test_multicast_key_distribution.sv
`timescale 1ns/10ps
// Both ends joined over the link; the bench drives both user sides
module test_multicast_key_distribution;
  localparam int SUP = 20;                 // Short supervision time
  logic                       core_clk, reset_n;
  logic                       assign_go, assign_key, assign_seq, assign_has_inst;
  logic                       retr_refuse, restart_go, refuse;
  logic                       retr_go, retr_key, retr_seq, retr_has_inst;
  logic                       busy, done_ok, done_rej, retr_busy, retr_done, retr_fail;
  logic                       key_valid, seq_valid;
  logic [mkd_pkg::INST_W-1:0] assign_inst, retr_inst, key_inst;
  logic [mkd_pkg::SEQ_W-1:0]  assign_seq_val, seq_out, cap_seq;
  logic [mkd_pkg::KEY_W-1:0]  cur_key, key_out, prev_key;
  logic [5:0]                 cap_f, cap_p;  // Kind fields, last message each way
  logic [3:0]                 ev;            // Completion pulses
  mkd_pkg::mkd_msg_t          typ_f, typ_p;  // Last message type each way
  int                         err_total, tests_run, nf, np;
  assign ev = {retr_fail, retr_done, done_rej, done_ok};
  mkd_link_if lnk ();
  mkd_fixed_side mkd_fixed_side_i (.core_clk, .reset_n, .link(lnk), .assign_go, .assign_key,
    .assign_seq, .assign_has_inst, .assign_inst, .assign_seq_val, .retr_refuse, .restart_go,
    .busy, .done_ok, .done_rej, .cur_key);
  mkd_portable_side #(.SUP_CYCLES(SUP)) mkd_portable_side_i (.core_clk, .reset_n, .link(lnk),
    .refuse, .retr_go, .retr_key, .retr_seq, .retr_has_inst, .retr_inst, .retr_busy, .retr_done,
    .retr_fail, .key_valid, .key_out, .key_inst, .seq_valid, .seq_out);
  mkd_link_props #(.SUP_CYCLES(SUP)) mkd_link_props_i (.core_clk, .reset_n,
    .f2p_valid(lnk.f2p_valid), .f2p_type(lnk.f2p_type), .f2p_has_key(lnk.f2p_has_key),
    .f2p_has_seq(lnk.f2p_has_seq), .f2p_has_inst(lnk.f2p_has_inst), .f2p_inst(lnk.f2p_inst),
    .f2p_key(lnk.f2p_key), .f2p_seq(lnk.f2p_seq), .f2p_restart(lnk.f2p_restart),
    .p2f_valid(lnk.p2f_valid), .p2f_type(lnk.p2f_type), .p2f_has_key(lnk.p2f_has_key),
    .p2f_has_seq(lnk.p2f_has_seq), .p2f_has_inst(lnk.p2f_has_inst), .p2f_inst(lnk.p2f_inst),
    .link_encrypted(lnk.link_encrypted));
  // Latch the last message each way and count them
  always @(posedge core_clk) begin
    if (lnk.f2p_valid) begin
      typ_f <= lnk.f2p_type;
      cap_f <= {lnk.f2p_has_key, lnk.f2p_has_seq, lnk.f2p_has_inst, lnk.f2p_inst};
      cap_seq <= lnk.f2p_seq;
      nf <= nf + 1;
    end
    if (lnk.p2f_valid) begin
      typ_p <= lnk.p2f_type;
      cap_p <= {lnk.p2f_has_key, lnk.p2f_has_seq, lnk.p2f_has_inst, lnk.p2f_inst};
      np <= np + 1;
    end
  end
  task automatic conclude();
    if (err_total == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One edge, then let its updates land
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  // Bounded wait for one completion pulse
  task automatic wait_ev(input int w, input int lim);
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (ev[w] !== 1'h1 && n < lim);
    if (ev[w] !== 1'h1) begin
      err_total++;
      $display("[ERR] %0t completion pulse missing", $time);
      conclude();
    end
  endtask
  task automatic go_assign(input logic k, s, hi, input logic [2:0] ins, input logic [47:0] sv);
    @(posedge core_clk) {assign_key, assign_seq, assign_has_inst, assign_inst, assign_seq_val,
      assign_go} <= {k, s, hi, ins, sv, 1'h1};
    @(posedge core_clk) assign_go <= 1'h0;
  endtask
  // Drop the link in the edge the request leaves, so the first one is lost
  task automatic go_retr(input logic k, s, hi, input logic [2:0] ins, input logic drop);
    @(posedge core_clk) {retr_key, retr_seq, retr_has_inst, retr_inst, retr_go} <= {k, s, hi, ins, 1'h1};
    @(posedge core_clk) retr_go <= 1'h0;
    if (drop) lnk.link_encrypted <= 1'h0;
  endtask
  task automatic t_assign(input logic k, s, hi, input logic [2:0] ins, input logic [47:0] sv);
    prev_key = cur_key;
    go_assign(k, s, hi, ins, sv);
    wait_ev(0, 20);
    chk(typ_f, mkd_pkg::MKD_MSG_SUGGEST);
    chk(cap_f[5:3], {k, s, hi});
    chk(cap_seq, s ? sv : '0);
    chk(typ_p, mkd_pkg::MKD_MSG_ACCEPT);
    chk(cap_p, cap_f);
    if (hi) chk(cap_f[2:0], ins);
    if (k) begin
      chk(key_out, cur_key);
      chk(key_valid, 1'h1);
      chk(key_inst, hi ? ins : 3'h0);
      chk(cur_key != prev_key && cur_key != '0, 1'h1);
    end
    if (s) chk(seq_out, sv);
    if (s) chk(seq_valid, 1'h1);
  endtask
  task automatic t_reject_assign();
    @(posedge core_clk) refuse <= 1'h1;
    go_assign(1'h1, 1'h1, 1'h1, 3'h6, 48'h0000_0000_00aa);
    wait_ev(1, 20);
    chk(typ_p, mkd_pkg::MKD_MSG_REJECT);
    chk(cap_p, cap_f);
    @(posedge core_clk) refuse <= 1'h0;
  endtask
  // Nothing may leave while the link is clear
  task automatic t_clear_link();
    int n0;
    @(posedge core_clk) lnk.link_encrypted <= 1'h0;
    n0 = nf;
    go_assign(1'h1, 1'h1, 1'h0, 3'h0, 48'h0000_0000_0001);
    repeat (10) tick();
    chk(nf - n0, 0);
    chk(busy, 1'h0);
    @(posedge core_clk) lnk.link_encrypted <= 1'h1;
  endtask
  task automatic t_retr(input logic k, s, hi, input logic [2:0] ins, input logic rf);
    int p0;
    @(posedge core_clk) retr_refuse <= rf;
    go_retr(k, s, hi, ins, 1'h0);
    wait_ev(rf ? 3 : 2, 20);
    chk(typ_p, mkd_pkg::MKD_MSG_REQUEST);
    chk(cap_f, cap_p);
    chk(typ_f, rf ? mkd_pkg::MKD_MSG_REJECT : mkd_pkg::MKD_MSG_SUGGEST);
    p0 = np;
    repeat (3) tick();
    chk(np - p0, 0);
    chk(retr_busy, 1'h0);
    if (!rf && k) chk(key_out, cur_key);
    if (!rf && s) chk(seq_out, assign_seq_val);
    @(posedge core_clk) retr_refuse <= 1'h0;
  endtask
  // Lost first request: resend, restart by notify, or abort
  task automatic t_retry(input int mode);
    int t0, cyc, lo;
    go_retr(1'h1, 1'h1, 1'h0, 3'h0, 1'h1);
    t0 = $time;
    if (mode != 2) begin
      repeat (4) @(posedge core_clk);
      lnk.link_encrypted <= 1'h1;
    end
    if (mode == 1) begin
      repeat (4) @(posedge core_clk);
      restart_go <= 1'h1;
      @(posedge core_clk) restart_go <= 1'h0;
    end
    wait_ev(mode == 2 ? 3 : 2, 3 * SUP);
    cyc = ($time - t0) / 4;
    lo = mode == 0 ? SUP - 1 : mode == 1 ? SUP + 8 : 2 * SUP - 2;
    chk(cyc >= lo && cyc <= lo + 7, 1'h1);
    @(posedge core_clk) lnk.link_encrypted <= 1'h1;
  endtask
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    {assign_go, assign_key, assign_seq, assign_has_inst, assign_inst, assign_seq_val} = '0;
    {retr_refuse, restart_go, refuse, retr_go, retr_key, retr_seq, retr_has_inst, retr_inst} = '0;
    {err_total, tests_run, nf, np} = '0;
    reset_n = 1'h0;
    lnk.link_encrypted = 1'h1;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'h1;
    for (int i = 0; i < 9; i++)
      t_assign(i % 3 != 1, i % 3 != 0, i < 8, i == 8 ? 3'h7 : i[2:0], 48'h8000_0000_0000 + i);
    t_reject_assign();
    t_clear_link();
    t_retr(1'h1, 1'h1, 1'h1, 3'h5, 1'h0);
    t_retr(1'h0, 1'h1, 1'h0, 3'h0, 1'h0);
    t_retr(1'h1, 1'h0, 1'h1, 3'h2, 1'h1);
    for (int m = 0; m < 3; m++) t_retry(m);
    conclude();
  end
endmodule // test_multicast_key_distribution
